/* File: rtl/tcpg_top.sv */
// three channel pulse generator with apb registers and interrupts
//
// How it works
// - three independent channels, each with pin and register at 0x010020/24/28
// - output stays high for high count plus one divided periods
// - output stays low for low count plus one divided periods
// - divider code n divides the count clock by two to the n
// - bit 3 reads pending flag; writing one clears it
// - bit 2 enables the interrupt raised at each completed cycle
// - bit 0 enables pulse generation
// - bit 1 is reserved, has no function and reads zero
// - an enabled channel starts every sequence in the high phase
// - count clock is the peripheral clock, here core_clk
`timescale 1ns/1ps
`default_nettype none

module tcpg_top (
   input wire logic core_clk,
   input wire logic rst,
   input wire tcpg_pkg::tcpg_addr_t paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire tcpg_pkg::tcpg_word_t pwdata,
   output tcpg_pkg::tcpg_word_t prdata,
   output logic pready,
   output logic pslverr,
   output logic [`TCPG_CHANS-1:0] pwm_o,
   output logic [`TCPG_CHANS-1:0] irq_chan_o,
   output logic irq_o
);
   import tcpg_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      tcpg_cfg_t [`TCPG_CHANS-1:0] cfg;
      logic [`TCPG_CHANS-1:0] pend;
      logic [`TCPG_CHANS-1:0] irq_en;
      logic pready;
      tcpg_word_t prdata;
      logic pslverr;
      logic [`TCPG_CHANS-1:0] irq_chan;
      logic irq;
   } tcpg_top_st_t;

   tcpg_top_st_t st_ff;
   tcpg_top_st_t nxt_st;

   logic [`TCPG_CHANS-1:0] done_w;
   logic [`TCPG_CHANS-1:0] pulse_w;
   logic [`TCPG_CHANS-1:0] run_w;
   logic [`TCPG_CHANS-1:0] clr;
   logic [`TCPG_CHANS-1:0] ie_vec;
   logic setup_ph;
   logic access_ph;
   tcpg_reg_t sel;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // address to register
   function automatic tcpg_reg_t reg_decode(input tcpg_addr_t a);
      case (a)
         `TCPG_OFF_CHAN0: reg_decode = TCPG_REG_CH0;
         `TCPG_OFF_CHAN1: reg_decode = TCPG_REG_CH1;
         `TCPG_OFF_CHAN2: reg_decode = TCPG_REG_CH2;
         `TCPG_OFF_IRQ_STAT: reg_decode = TCPG_REG_STAT;
         `TCPG_OFF_IRQ_CLR: reg_decode = TCPG_REG_CLR;
         `TCPG_OFF_IRQ_EN: reg_decode = TCPG_REG_EN;
         default: reg_decode = TCPG_REG_NONE;
      endcase
   endfunction

   // channel settings and pending flag to register word
   function automatic tcpg_word_t cfg_word(input tcpg_cfg_t c, input logic p);
      cfg_word = `TCPG_CFG_RESET;
      cfg_word[`TCPG_HI_MSB:`TCPG_HI_LSB] = c.hi;
      cfg_word[`TCPG_LO_MSB:`TCPG_LO_LSB] = c.lo;
      cfg_word[`TCPG_DIV_MSB:`TCPG_DIV_LSB] = c.div;
      cfg_word[`TCPG_PEND_BIT] = p;
      cfg_word[`TCPG_IE_BIT] = c.ie;
      cfg_word[`TCPG_RSVD_BIT] = 1'b0;
      cfg_word[`TCPG_EN_BIT] = c.en;
   endfunction

   // register word to channel settings, reserved bit dropped
   function automatic tcpg_cfg_t word_cfg(input tcpg_word_t w);
      word_cfg.hi = w[`TCPG_HI_MSB:`TCPG_HI_LSB];
      word_cfg.lo = w[`TCPG_LO_MSB:`TCPG_LO_LSB];
      word_cfg.div = w[`TCPG_DIV_MSB:`TCPG_DIV_LSB];
      word_cfg.ie = w[`TCPG_IE_BIT];
      word_cfg.en = w[`TCPG_EN_BIT];
   endfunction

   // status word: pending, live pin levels, running channels
   function automatic tcpg_word_t stat_word(
      input logic [`TCPG_CHANS-1:0] p,
      input logic [`TCPG_CHANS-1:0] lvl,
      input logic [`TCPG_CHANS-1:0] run
   );
      stat_word = `TCPG_CFG_RESET;
      stat_word[`TCPG_CHANS-1:0] = p;
      stat_word[`TCPG_STAT_LVL_LSB +: `TCPG_CHANS] = lvl;
      stat_word[`TCPG_STAT_RUN_LSB +: `TCPG_CHANS] = run;
   endfunction

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   for (genvar i = 0; i < `TCPG_CHANS; i++) begin : g_chan
      tcpg_chan_if ch_if ();

      // settings go out, pin level and cycle end come back
      assign ch_if.cfg = st_ff.cfg[i];
      assign done_w[i] = ch_if.done;
      assign pulse_w[i] = ch_if.pulse;
      assign run_w[i] = ch_if.running;

      // core_clk stands in as the undivided count clock
      tcpg_channel u_chan (
         .core_clk (core_clk),
         .rst (rst),
         .ch (ch_if.chan)
      );
   end

   // ----------------------------------------------------------------
   // bus phases
   // ----------------------------------------------------------------

   // setup is answered next cycle; access edge commits
   assign setup_ph = psel && !penable;
   assign access_ph = psel && penable && st_ff.pready;
   assign sel = reg_decode(paddr);

   // interrupt enable bits of the channel registers
   always_comb begin
      for (int i = 0; i < `TCPG_CHANS; i++) begin
         ie_vec[i] = st_ff.cfg[i].ie;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      clr = '0;
      nxt_st.pready = 1'b0;

      // setup: fetch read data and error for the access phase
      if (setup_ph) begin
         nxt_st.pready = 1'b1;
         nxt_st.pslverr = (sel == TCPG_REG_NONE);
         nxt_st.prdata = `TCPG_CFG_RESET;
         if (!pwrite) begin
            case (sel)
               TCPG_REG_CH0: nxt_st.prdata = cfg_word(st_ff.cfg[0], st_ff.pend[0]);
               TCPG_REG_CH1: nxt_st.prdata = cfg_word(st_ff.cfg[1], st_ff.pend[1]);
               TCPG_REG_CH2: nxt_st.prdata = cfg_word(st_ff.cfg[2], st_ff.pend[2]);
               TCPG_REG_STAT: nxt_st.prdata = stat_word(st_ff.pend, pulse_w, run_w);
               TCPG_REG_EN: nxt_st.prdata[`TCPG_CHANS-1:0] = st_ff.irq_en;
               default: nxt_st.prdata = `TCPG_CFG_RESET;
            endcase
         end
      end

      // access: writes take effect on this edge only
      if (access_ph) begin
         nxt_st.pslverr = 1'b0;
         if (pwrite) begin
            case (sel)
               TCPG_REG_CH0: begin
                  nxt_st.cfg[0] = word_cfg(pwdata);
                  clr[0] = pwdata[`TCPG_PEND_BIT];
               end
               TCPG_REG_CH1: begin
                  nxt_st.cfg[1] = word_cfg(pwdata);
                  clr[1] = pwdata[`TCPG_PEND_BIT];
               end
               TCPG_REG_CH2: begin
                  nxt_st.cfg[2] = word_cfg(pwdata);
                  clr[2] = pwdata[`TCPG_PEND_BIT];
               end
               TCPG_REG_CLR: clr = pwdata[`TCPG_CHANS-1:0];
               TCPG_REG_EN: nxt_st.irq_en = pwdata[`TCPG_CHANS-1:0];
               default: nxt_st.irq_en = st_ff.irq_en;
            endcase
         end
      end

      // pending flags: cycle end sets, set wins over clear
      nxt_st.pend = (st_ff.pend & ~clr) | done_w;

      // channel requests and the merged interrupt line
      nxt_st.irq_chan = nxt_st.pend & ie_vec;
      for (int i = 0; i < `TCPG_CHANS; i++) begin
         nxt_st.irq_chan[i] = nxt_st.pend[i] & nxt_st.cfg[i].ie;
      end
      nxt_st.irq = |(nxt_st.irq_chan & nxt_st.irq_en);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.irq_en <= `TCPG_IRQ_EN_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign pwm_o = pulse_w;
   assign irq_chan_o = st_ff.irq_chan;
   assign irq_o = st_ff.irq;

endmodule // tcpg_top

`default_nettype wire

/* File: rtl/tcpg_defines.svh */
// register map, field positions, reset values and counts of the pulse generator
`ifndef TCPG_DEFINES_SVH
`define TCPG_DEFINES_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define TCPG_ADDR_W 24
`define TCPG_OFF_CHAN0 24'h010020
`define TCPG_OFF_CHAN1 24'h010024
`define TCPG_OFF_CHAN2 24'h010028
`define TCPG_OFF_IRQ_STAT 24'h010030
`define TCPG_OFF_IRQ_CLR 24'h010034
`define TCPG_OFF_IRQ_EN 24'h010038

// ----------------------------------------------------------------
// channel configuration fields
// ----------------------------------------------------------------
`define TCPG_HI_MSB 31
`define TCPG_HI_LSB 20
`define TCPG_LO_MSB 19
`define TCPG_LO_LSB 8
`define TCPG_DIV_MSB 7
`define TCPG_DIV_LSB 4
`define TCPG_PEND_BIT 3
`define TCPG_IE_BIT 2
`define TCPG_RSVD_BIT 1
`define TCPG_EN_BIT 0

// ----------------------------------------------------------------
// interrupt status layout, sizes and reset values
// ----------------------------------------------------------------
`define TCPG_STAT_LVL_LSB 4
`define TCPG_STAT_RUN_LSB 8
`define TCPG_CHANS 3
`define TCPG_CNT_W 12
`define TCPG_DIV_W 4
`define TCPG_PRE_W 15
`define TCPG_PRE_ALL 15'h7fff
`define TCPG_PRE_TOP 4'hf
`define TCPG_CFG_RESET 32'h00000000
`define TCPG_IRQ_EN_RESET 3'h7
`define TCPG_PERIPH_CLK_MHZ 96

`endif

/* File: rtl/tcpg_pkg.sv */
// types and helper functions of the three channel pulse generator
`include "tcpg_defines.svh"

package tcpg_pkg;

   typedef logic [`TCPG_ADDR_W-1:0] tcpg_addr_t;
   typedef logic [31:0] tcpg_word_t;

   // one channel's software settings
   typedef struct packed {
      logic [`TCPG_CNT_W-1:0] hi;
      logic [`TCPG_CNT_W-1:0] lo;
      logic [`TCPG_DIV_W-1:0] div;
      logic ie;
      logic en;
   } tcpg_cfg_t;

   // decoded register selection
   typedef enum logic [2:0] {
      TCPG_REG_CH0,
      TCPG_REG_CH1,
      TCPG_REG_CH2,
      TCPG_REG_STAT,
      TCPG_REG_CLR,
      TCPG_REG_EN,
      TCPG_REG_NONE
   } tcpg_reg_t;

   // prescaler mask: low div bits set
   function automatic logic [`TCPG_PRE_W-1:0] tcpg_div_mask(input logic [`TCPG_DIV_W-1:0] div);
      tcpg_div_mask = `TCPG_PRE_ALL >> (`TCPG_PRE_TOP - div);
   endfunction

endpackage

/* File: rtl/tcpg_chan_if.sv */
// settings and results passed between the register file and one channel
`timescale 1ns/1ps
`default_nettype none

interface tcpg_chan_if;
   import tcpg_pkg::*;
   tcpg_cfg_t cfg;
   logic pulse;
   logic done;
   logic running;

   modport regs (output cfg, input pulse, input done, input running);
   modport chan (input cfg, output pulse, output done, output running);
endinterface

`default_nettype wire

/* File: rtl/tcpg_channel.sv */
// one pulse channel: prescaler, phase counter and output level
`timescale 1ns/1ps
`default_nettype none

module tcpg_channel (
   input wire logic core_clk,
   input wire logic rst,
   tcpg_chan_if.chan ch
);
   import tcpg_pkg::*;

   typedef struct packed {
      logic [`TCPG_PRE_W-1:0] pre;
      logic [`TCPG_CNT_W-1:0] cnt;
      logic run;
      logic low_phase;
      logic pulse;
      logic done;
   } tcpg_chan_st_t;

   tcpg_chan_st_t st_ff;
   tcpg_chan_st_t nxt_st;
   logic [`TCPG_PRE_W-1:0] mask;
   logic tick;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      mask = tcpg_div_mask(ch.cfg.div);
      tick = (st_ff.pre & mask) == mask;
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      if (!ch.cfg.en) begin
         nxt_st = '0;
      end else if (!st_ff.run) begin
         nxt_st.run = 1'b1;
         nxt_st.pulse = 1'b1;
      end else begin
         nxt_st.pre = st_ff.pre + 1'b1;
         if (tick) begin
            if (!st_ff.low_phase) begin
               if (st_ff.cnt == ch.cfg.hi) begin
                  nxt_st.low_phase = 1'b1;
                  nxt_st.pulse = 1'b0;
                  nxt_st.cnt = '0;
               end else begin
                  nxt_st.cnt = st_ff.cnt + 1'b1;
               end
            end else begin
               if (st_ff.cnt == ch.cfg.lo) begin
                  nxt_st.low_phase = 1'b0;
                  nxt_st.pulse = 1'b1;
                  nxt_st.done = 1'b1;
                  nxt_st.cnt = '0;
               end else begin
                  nxt_st.cnt = st_ff.cnt + 1'b1;
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign ch.pulse = st_ff.pulse;
   assign ch.done = st_ff.done;
   assign ch.running = st_ff.run;

endmodule // tcpg_channel

`default_nettype wire

/* File: verification/tcpg_pin_mon.sv */
// pin watcher standing in for the device on one pulse output
`timescale 1ns/1ps
`default_nettype none
module tcpg_pin_mon (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pin,
   output int hi_len,
   output int lo_len
);
   int run_ff;
   logic last_ff;
   // length in cycles of each finished high and low run
   always @(negedge core_clk or posedge rst) begin
      if (rst) begin
         run_ff <= 0;
         last_ff <= 1'b0;
         hi_len <= 0;
         lo_len <= 0;
      end else if (pin !== last_ff) begin
         run_ff <= 1;
         last_ff <= pin;
         if (last_ff) begin
            hi_len <= run_ff;
         end else begin
            lo_len <= run_ff;
         end
      end else begin
         run_ff <= run_ff + 1;
      end
   end
endmodule // tcpg_pin_mon
`default_nettype wire

/* File: verification/tcpg_chk.sv */
// bus and interrupt checks on the pulse generator ports
`timescale 1ns/1ps
`default_nettype none
`include "tcpg_defines.svh"
module tcpg_chk (
   input wire logic core_clk,
   input wire logic rst,
   input wire tcpg_pkg::tcpg_addr_t paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire tcpg_pkg::tcpg_word_t pwdata,
   input wire tcpg_pkg::tcpg_word_t prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [`TCPG_CHANS-1:0] pwm_o,
   input wire logic [`TCPG_CHANS-1:0] irq_chan_o,
   input wire logic irq_o
);
   logic mapped;
   logic chan;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // address decode of the six registers
   assign chan = paddr inside {`TCPG_OFF_CHAN0, `TCPG_OFF_CHAN1, `TCPG_OFF_CHAN2};
   assign mapped = chan || paddr inside {`TCPG_OFF_IRQ_STAT, `TCPG_OFF_IRQ_CLR,
      `TCPG_OFF_IRQ_EN};
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_rd;
      s_setup ##0 !pwrite;
   endsequence
   property p_rdy;
      s_setup |=> pready;
   endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_one;
      pready |-> psel && penable && $past(psel && !penable);
   endproperty
   a_one: assert property (p_one) else $error("ready outside access");
   property p_err;
      s_rd ##0 !mapped |=> pslverr && prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("unmapped read wrong");
   property p_ok;
      s_setup ##0 mapped |=> !pslverr;
   endproperty
   a_ok: assert property (p_ok) else $error("error on mapped address");
   property p_errrdy;
      pslverr |-> pready;
   endproperty
   a_errrdy: assert property (p_errrdy) else $error("error without ready");
   property p_rsv;
      s_rd ##0 chan |=> !prdata[`TCPG_RSVD_BIT];
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
   property p_clr;
      s_rd ##0 paddr == `TCPG_OFF_IRQ_CLR |=> prdata == 32'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("clear register reads data");
   property p_irq;
      irq_o |-> |irq_chan_o;
   endproperty
   a_irq: assert property (p_irq) else $error("irq without channel request");
endmodule // tcpg_chk
`default_nettype wire

/* File: verification/testbench.sv */
// testbench for the three channel pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "tcpg_defines.svh"
module testbench;
   import tcpg_pkg::*;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, irq_o, err;
   tcpg_addr_t paddr;
   tcpg_word_t pwdata, prdata, rd;
   logic [2:0] pwm_o, irq_chan_o;
   int hi_len[3], lo_len[3];
   int miscompares = 0, checks = 0, cycles = 0;
   tcpg_top u_dut (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .pwm_o, .irq_chan_o, .irq_o);
   for (genvar i = 0; i < 3; i++) begin : g_mon
      tcpg_pin_mon u_mon (.core_clk, .rst, .pin(pwm_o[i]), .hi_len(hi_len[i]),
         .lo_len(lo_len[i]));
   end
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // one apb transfer, waits for ready
   task automatic apb(input logic w, input tcpg_addr_t a, input tcpg_word_t d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) begin
         @(posedge core_clk);
      end
      // ready seen at this edge: take the answer here, then release
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_reset;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, `TCPG_OFF_CHAN0 + 24'(4 * i), '0);
         chk("cfg reset", rd, `TCPG_CFG_RESET);
      end
      apb(1'b0, `TCPG_OFF_IRQ_EN, '0);
      chk("irq_en reset", rd, 32'(`TCPG_IRQ_EN_RESET));
      chk("pins idle", 32'(pwm_o), 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_run;
      int eh[3] = '{6, 4, 4};
      int el[3] = '{4, 12, 1};
      apb(1'b1, `TCPG_OFF_CHAN0, 32'h00200115);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk("start high", 32'(pwm_o[0]), 32'h1);
      apb(1'b1, `TCPG_OFF_CHAN1, 32'h00000221);
      apb(1'b1, `TCPG_OFF_CHAN2, 32'h00300001);
      repeat (80) @(posedge core_clk);
      for (int i = 0; i < 3; i++) begin
         chk("high run", hi_len[i], eh[i]);
         chk("low run", lo_len[i], el[i]);
      end
      apb(1'b0, `TCPG_OFF_IRQ_STAT, '0);
      chk("stat pend run", rd & 32'hffffff8f, 32'h00000707);
      apb(1'b0, `TCPG_OFF_CHAN1, '0);
      chk("pend no ie", 32'(rd[3]), 32'h1);
      chk("chan irqs", 32'(irq_chan_o), 32'h1);
      chk("irq on", 32'(irq_o), 32'h1);
      apb(1'b1, `TCPG_OFF_IRQ_EN, '0);
      repeat (2) @(negedge core_clk);
      chk("irq gated", 32'(irq_o), 32'h0);
      apb(1'b1, `TCPG_OFF_IRQ_EN, 32'h7);
      $display("t_run done");
   endtask
   task automatic t_clear;
      apb(1'b1, `TCPG_OFF_CHAN0, '0);
      apb(1'b1, `TCPG_OFF_CHAN0, 32'h8);
      apb(1'b0, `TCPG_OFF_CHAN0, '0);
      chk("w1c chan0", rd, 32'h0);
      chk("irq cleared", 32'(irq_chan_o[0]), 32'h0);
      apb(1'b1, `TCPG_OFF_CHAN1, '0);
      apb(1'b0, `TCPG_OFF_CHAN1, '0);
      chk("pend kept", rd, 32'h8);
      apb(1'b1, `TCPG_OFF_IRQ_CLR, 32'h2);
      apb(1'b0, `TCPG_OFF_CHAN1, '0);
      chk("clr reg", rd, 32'h0);
      apb(1'b0, `TCPG_OFF_IRQ_CLR, '0);
      chk("clr reads zero", rd, 32'h0);
      apb(1'b1, `TCPG_OFF_CHAN2, 32'h00300002);
      apb(1'b0, `TCPG_OFF_CHAN2, '0);
      chk("rsvd bit", rd, 32'h00300008);
      chk("pins off", 32'(pwm_o), 32'h0);
      apb(1'b1, `TCPG_OFF_CHAN2, 32'h00300001);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk("restart high", 32'(pwm_o[2]), 32'h1);
      $display("t_clear done");
   endtask
   task automatic t_bad;
      apb(1'b1, 24'h010040, 32'hffffffff);
      chk("wr err", 32'(err), 32'h1);
      apb(1'b0, 24'h010040, '0);
      chk("rd err", 32'(err), 32'h1);
      chk("rd zero", rd, 32'h0);
      $display("t_bad done");
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles > 3000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_run();
      t_clear();
      t_bad();
      stop_test();
   end
endmodule // testbench
bind tcpg_top tcpg_chk u_chk (.core_clk, .rst, .paddr, .psel, .penable, .pwrite,
   .pwdata, .prdata, .pready, .pslverr, .pwm_o, .irq_chan_o, .irq_o);
`default_nettype wire
